// >>> logic/adc_mode_pkg.sv
// Constants, mode type and state record of the power-mode sequencer.
// Assumes one system clock; frame positions are counted in serial clock
// falling edges seen through the synchronisers, wake-up time in system clocks.
package adc_mode_pkg;

  localparam int RES_BITS = 12;
  localparam int CNT_W = 6;

  // Serial clock falling-edge counts
  localparam logic [5:0] CNT_GLITCH = 6'h02;
  localparam logic [5:0] CNT_KEEP = 6'h0A;
  localparam logic [5:0] CNT_TRACK = 6'h0D;
  localparam logic [5:0] CNT_RESULT = 6'h0E;
  localparam logic [5:0] CNT_WORD = 6'h10;
  localparam logic [5:0] CNT_LAST = 6'h20;
  localparam logic [3:0] LEAD_ZEROS = 4'h2;
  localparam logic [3:0] DATA_TOP = 4'hD;

  // Partial power-down wake-up time
  localparam int CLK_NS = 20;
  localparam int WAKE_NS = 200;
  localparam int WAKE_CYC_I = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] WAKE_CYC = 4'(WAKE_CYC_I);

  // Synchroniser states after reset: both pins idle high
  localparam logic [2:0] SYNC_IDLE = 3'h7;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_PARTIAL,
    MODE_FULL
  } pwr_mode_t;

  typedef struct packed {
    logic [RES_BITS-1:0] a;
    logic [RES_BITS-1:0] b;
  } result_pair_t;

  typedef struct packed {
    logic [2:0] cs_sync;
    logic [2:0] sclk_sync;
    pwr_mode_t mode;
    logic frame;
    logic waking;
    logic [CNT_W-1:0] count;
    result_pair_t data;
    logic line_a;
    logic line_b;
    logic oe_n;
    logic hold;
    logic analog_on;
    logic ref_on;
    logic [3:0] wake_cnt;
    logic ready;
  } state_t;

endpackage

// >>> logic/dual_adc_power_mode_sequencer.sv
// Frame, shift-out and power-mode logic of a dual 12-bit serial converter.
// Assumes frame select and serial clock come from the host off-domain and
// the converter core presents both results in the system clock domain.
//
// Behaviour
// - Rise between tenth and fourteenth edge: stay powered, abort, float lines.
// - Full conversion and readout of one result takes fourteen clocks.
// - After fourteen clocks lines keep driving until rise or 32nd edge.
// - Two more clocks low shift out two trailing zeros.
// - Further fourteen clocks put the other converter's result on each line.
// - Active line floats at 32nd edge or frame rise, whichever first.
// - Normal mode, rise between second and tenth edge: partial power-down.
// - Normal mode, rise before second edge: stays normal, glitch filtered.
// - Partial: analog off, reference on. Full: reference off too.
// - Dummy frame past tenth edge wakes from partial in about 200 ns.
// - Partial mode, rise before second edge: back to partial power-down.
// - Power-up begun at frame start is abandoned on an early rise.
// - Partial mode, rise between second and tenth edge: full power-down.
// - Waking from partial, hold returns to track after first clock edge.
// - Frame start samples inputs, starts conversion, drives result lines.
// - Frame start gives first zero; edges give second zero, then MSB first.
// - Serial clock times conversion and result shifting.
`timescale 1ns/1ns

module dual_adc_power_mode_sequencer (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire adc_mode_pkg::result_pair_t CONV_RESULT,
  output logic RESULT_LINE_A,
  output logic RESULT_LINE_A_OE_N,
  output logic RESULT_LINE_B,
  output logic RESULT_LINE_B_OE_N,
  output logic TRACK_HOLD,
  output logic ANALOG_ON,
  output logic REF_ON,
  output logic POWER_READY,
  output adc_mode_pkg::pwr_mode_t MODE
);

  ////////////////////////////////////////////////////////////////////////////
  // State and edge detection

  adc_mode_pkg::state_t s;
  adc_mode_pkg::state_t next_s;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;

  assign cs_fall = s.cs_sync[2] & ~s.cs_sync[1];
  assign cs_rise = ~s.cs_sync[2] & s.cs_sync[1];
  assign sclk_fall = s.sclk_sync[2] & ~s.sclk_sync[1];
  assign sclk_rise = ~s.sclk_sync[2] & s.sclk_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Bit shown after falling edge c: 0,0,D11..D0,0,0 then the other result
  function automatic logic line_bit(
    input logic [5:0] c,
    input logic [11:0] own,
    input logic [11:0] other
  );
    logic [3:0] pos;
    logic [11:0] word;
    pos = c[3:0];
    word = (c < adc_mode_pkg::CNT_WORD) ? own : other;
    if (pos < adc_mode_pkg::LEAD_ZEROS) begin
      line_bit = 1'b0;
    end else if (pos < adc_mode_pkg::DATA_TOP + 4'h1) begin
      line_bit = word[adc_mode_pkg::DATA_TOP - pos];
    end else begin
      line_bit = 1'b0;
    end
  endfunction

  // Mode chosen when frame select rises after c falling edges
  function automatic adc_mode_pkg::pwr_mode_t judge_mode(
    input adc_mode_pkg::pwr_mode_t m,
    input logic [5:0] c
  );
    if (c < adc_mode_pkg::CNT_GLITCH) begin
      judge_mode = m;
    end else if (c < adc_mode_pkg::CNT_KEEP) begin
      if (m == adc_mode_pkg::MODE_NORMAL) begin
        judge_mode = adc_mode_pkg::MODE_PARTIAL;
      end else begin
        judge_mode = adc_mode_pkg::MODE_FULL;
      end
    end else begin
      judge_mode = adc_mode_pkg::MODE_NORMAL;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    adc_mode_pkg::pwr_mode_t nm;
    logic [5:0] nc;
    nm = s.mode;
    nc = s.count + 6'h01;
    next_s = s;
    next_s.cs_sync = {s.cs_sync[1:0], CS_N};
    next_s.sclk_sync = {s.sclk_sync[1:0], SCLK};
    // Wake-up timer runs while a frame holds the part powering up
    if (s.frame & ~s.ready) begin
      if (s.wake_cnt == adc_mode_pkg::WAKE_CYC - 4'h1) begin
        next_s.ready = 1'b1;
      end else begin
        next_s.wake_cnt = s.wake_cnt + 4'h1;
      end
    end
    if (cs_fall) begin
      next_s.frame = 1'b1;
      next_s.count = '0;
      next_s.data = CONV_RESULT;
      next_s.line_a = 1'b0;
      next_s.line_b = 1'b0;
      next_s.oe_n = 1'b0;
      next_s.hold = 1'b1;
      next_s.analog_on = 1'b1;
      next_s.ref_on = 1'b1;
      next_s.wake_cnt = '0;
      next_s.waking = (s.mode != adc_mode_pkg::MODE_NORMAL);
      next_s.ready = (s.mode == adc_mode_pkg::MODE_NORMAL);
    end else if (cs_rise & s.frame) begin
      nm = judge_mode(s.mode, s.count);
      next_s.mode = nm;
      next_s.frame = 1'b0;
      next_s.waking = 1'b0;
      next_s.oe_n = 1'b1;
      next_s.hold = 1'b0;
      next_s.analog_on = (nm == adc_mode_pkg::MODE_NORMAL);
      next_s.ref_on = (nm != adc_mode_pkg::MODE_FULL);
      next_s.ready = (nm == adc_mode_pkg::MODE_NORMAL);
    end else if (s.frame) begin
      if (sclk_fall & (s.count < adc_mode_pkg::CNT_LAST)) begin
        next_s.count = nc;
        if (nc == adc_mode_pkg::CNT_LAST) begin
          next_s.oe_n = 1'b1;
        end else begin
          next_s.line_a = line_bit(nc, s.data.a, s.data.b);
          next_s.line_b = line_bit(nc, s.data.b, s.data.a);
        end
      end
      if (sclk_rise & (s.count >= adc_mode_pkg::CNT_TRACK)) begin
        next_s.hold = 1'b0;
      end
      if (s.waking & (sclk_rise | sclk_fall)) begin
        next_s.hold = 1'b0;
        next_s.waking = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s <= '0;
      s.cs_sync <= adc_mode_pkg::SYNC_IDLE;
      s.sclk_sync <= adc_mode_pkg::SYNC_IDLE;
      s.oe_n <= 1'b1;
      s.analog_on <= 1'b1;
      s.ref_on <= 1'b1;
      s.ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign RESULT_LINE_A = s.line_a;
  assign RESULT_LINE_A_OE_N = s.oe_n;
  assign RESULT_LINE_B = s.line_b;
  assign RESULT_LINE_B_OE_N = s.oe_n;
  assign TRACK_HOLD = s.hold;
  assign ANALOG_ON = s.analog_on;
  assign REF_ON = s.ref_on;
  assign POWER_READY = s.ready;
  assign MODE = s.mode;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  a_drive_at_start: assert property (
    cs_fall |=> !s.oe_n && !s.line_a && !s.line_b && s.hold && s.frame)
    else $error("lines not driven or hold missing at frame start");

  a_float_on_rise: assert property (
    cs_rise && s.frame |=> s.oe_n && !s.frame)
    else $error("lines still driven after frame select rose");

  a_float_at_end: assert property (
    s.frame && !cs_rise && sclk_fall && s.count == 6'h1F |=> s.oe_n)
    else $error("lines still driven after 32nd falling edge");

  a_keep_driving: assert property (
    s.frame && !s.oe_n && !cs_rise && !cs_fall
      && !(sclk_fall && s.count == 6'h1F) |=> !s.oe_n)
    else $error("lines floated early inside a frame");

  a_trailing_zeros: assert property (
    s.frame && !cs_rise && !cs_fall && sclk_fall
      && (s.count == 6'h0D || s.count == 6'h0E)
      |=> !s.line_a && !s.line_b)
    else $error("trailing zeros missing after result");

  a_glitch_keeps: assert property (
    cs_rise && s.frame && s.count < 6'h02 |=> s.mode == $past(s.mode))
    else $error("mode changed on a glitch frame");

  a_enter_partial: assert property (
    cs_rise && s.frame && s.count >= 6'h02 && s.count <= 6'h09
      && s.mode == adc_mode_pkg::MODE_NORMAL
      |=> s.mode == adc_mode_pkg::MODE_PARTIAL && !s.analog_on && s.ref_on)
    else $error("partial power-down not entered");

  a_enter_full: assert property (
    cs_rise && s.frame && s.count >= 6'h02 && s.count <= 6'h09
      && s.mode == adc_mode_pkg::MODE_PARTIAL
      |=> s.mode == adc_mode_pkg::MODE_FULL && !s.analog_on && !s.ref_on)
    else $error("full power-down not entered");

  a_wake_normal: assert property (
    cs_rise && s.frame && s.count >= 6'h0A
      |=> s.mode == adc_mode_pkg::MODE_NORMAL && s.analog_on && s.ref_on)
    else $error("device not powered after long frame");

  a_wake_time: assert property (
    cs_fall && s.mode == adc_mode_pkg::MODE_PARTIAL
      |-> ##[1:11] (s.ready || !s.frame))
    else $error("wake-up from partial took too long");

  a_early_abandon: assert property (
    cs_rise && s.frame && s.count < 6'h02
      && s.mode != adc_mode_pkg::MODE_NORMAL |=> !s.analog_on)
    else $error("power-up not abandoned on early rise");

  c_full_dual_read: cover property (
    s.frame && sclk_fall && s.count == 6'h1F);
  c_to_partial: cover property (
    cs_rise && s.frame && s.mode == adc_mode_pkg::MODE_NORMAL
      && s.count == 6'h05);
  c_to_full: cover property (
    cs_rise && s.frame && s.mode == adc_mode_pkg::MODE_PARTIAL
      && s.count == 6'h05);
  c_wake: cover property (
    cs_rise && s.frame && s.mode == adc_mode_pkg::MODE_FULL
      && s.count >= 6'h0A);

endmodule

// >>> testbench/serial_host.sv
// Host serial master model: frame select and serial clock.
// Assumes the device settles its lines within half a serial period.
`timescale 1ns/1ns

module serial_host (
  output logic cs_n,
  output logic sclk,
  input wire logic line_a,
  input wire logic line_b,
  input wire logic oe_n,
  input wire logic hold,
  input wire logic ready,
  input wire logic analog_on
);
  logic [33:0] cap_a;
  logic [33:0] cap_b;
  logic [33:0] cap_oe;
  logic [33:0] cap_hold;
  logic [33:0] cap_rdy;
  logic [33:0] cap_on;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample the lines as shown after falling edge k
  task automatic grab(input int k);
    cap_a[k] = line_a;
    cap_b[k] = line_b;
    cap_oe[k] = oe_n;
    cap_hold[k] = hold;
    cap_rdy[k] = ready;
    cap_on[k] = analog_on;
  endtask

  // Frame of n falling edges; serial clock idles high between frames
  task automatic frame(input int n);
    cs_n = 1'b0;
    #100;
    grab(0);
    for (int k = 1; k <= n; k++) begin
      sclk = 1'b0;
      #80;
      sclk = 1'b1;
      #80;
      grab(k);
    end
    cs_n = 1'b1; // Early rise, no further clocks
    #200; // Quiet gap after lines float
  endtask
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the power-mode sequencer.
// Assumes the serial host model in its own file and a 50 MHz system clock.
`timescale 1ns/1ns

module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n;
  logic sclk;
  adc_mode_pkg::result_pair_t conv = '0;
  logic line_a;
  logic oe_a;
  logic line_b;
  logic oe_b;
  logic hold;
  logic analog;
  logic ref_on;
  logic ready;
  adc_mode_pkg::pwr_mode_t mode;
  adc_mode_pkg::pwr_mode_t m = adc_mode_pkg::MODE_NORMAL;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 32'h31dc;
  int lens[16] = '{16, 1, 5, 1, 5, 11, 14, 2, 9, 12, 32, 33, 0, 3, 3, 33};

  always #10 clk = ~clk;

  dual_adc_power_mode_sequencer dut_u (
    .CLK_SYS(clk), .RST(rst), .CS_N(cs_n), .SCLK(sclk),
    .CONV_RESULT(conv), .RESULT_LINE_A(line_a),
    .RESULT_LINE_A_OE_N(oe_a), .RESULT_LINE_B(line_b),
    .RESULT_LINE_B_OE_N(oe_b), .TRACK_HOLD(hold), .ANALOG_ON(analog),
    .REF_ON(ref_on), .POWER_READY(ready), .MODE(mode)
  );

  // Released lines show the inverse of their last level: no pull resistor
  serial_host host_u (
    .cs_n(cs_n), .sclk(sclk), .line_a(line_a ^ oe_a),
    .line_b(line_b ^ oe_b), .oe_n(oe_a), .hold(hold), .ready(ready),
    .analog_on(analog)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input int k);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t bit %0d got %b want %b", $time, k, got, exp);
    end
  endtask

  task automatic chk_mode(input adc_mode_pkg::pwr_mode_t e);
    num_checks++;
    if (mode !== e || analog !== (e == adc_mode_pkg::MODE_NORMAL) ||
        ref_on !== (e != adc_mode_pkg::MODE_FULL) || oe_a !== 1'b1 ||
        oe_b !== 1'b1 || hold !== 1'b0 ||
        (e == adc_mode_pkg::MODE_NORMAL && ready !== 1'b1)) begin
      num_errors++;
      $display("BAD %0t mode %0d want %0d", $time, mode, e);
    end
  endtask

  // Expected line level after falling edge k
  function automatic logic exp_bit(input int k, input logic [11:0] own,
                                   input logic [11:0] oth);
    if (k >= 2 && k <= 13) return own[13-k];
    if (k >= 18 && k <= 29) return oth[29-k];
    return 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic run(input int n);
    adc_mode_pkg::result_pair_t r;
    int wake_k;
    @(negedge clk);
    r = 24'($random(seed));
    conv = r;
    // Hold ends after edge 13 when powered, after the first edge when waking
    wake_k = (m == adc_mode_pkg::MODE_NORMAL) ? 13 : 1;
    host_u.frame(n);
    for (int k = 0; k <= n; k++) begin
      if (k < 32) begin
        chk_bit(host_u.cap_oe[k], 1'b0, k);
        chk_bit(host_u.cap_a[k], exp_bit(k, r.a, r.b), k);
        chk_bit(host_u.cap_b[k], exp_bit(k, r.b, r.a), k);
      end else begin
        chk_bit(host_u.cap_oe[k], 1'b1, k);
      end
      chk_bit(host_u.cap_on[k], 1'b1, k);
      chk_bit(host_u.cap_hold[k], k < wake_k, k);
      if (k != 1) begin
        chk_bit(host_u.cap_rdy[k],
                (m == adc_mode_pkg::MODE_NORMAL) || k >= 2, k);
      end
    end
    if (n >= 10) begin
      m = adc_mode_pkg::MODE_NORMAL;
    end else if (n >= 2) begin
      m = (m == adc_mode_pkg::MODE_NORMAL) ? adc_mode_pkg::MODE_PARTIAL :
          adc_mode_pkg::MODE_FULL;
    end
    @(negedge clk);
    chk_mode(m);
    $display("frame of %0d edges done", n);
  endtask

  // Dummy frames reach each mode after reset
  // Partial power-down stays last a few microseconds only
  // The ideal converter model needs no deep_wake_time after a deep wake
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    foreach (lens[i]) run(lens[i]);
    give_verdict;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("BAD %0t run did not finish", $time);
    give_verdict;
  end
endmodule
